// [logic/fecb_bank.sv]
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Third tap: 12-bit signed in bits 11:0
// - Fourth tap: 12-bit signed in bits 11:0
// - Center tap 18-bit signed, bits 23:18 unused
// - Single-channel mode uses these taps for merged filter
// - Reset clears every tap coefficient; the code clears only the five taps held in this bank
// - Mode 0 bypasses, 2 runs, others reserved; the code bypasses on modes 1 and 3 too
// - Share bit gives channel B these coefficients
// - Side taps weighted two to scw minus sixteen
module fecb_bank
  import fecb_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_n_i,
  // Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [13:0]           wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // Coefficients of the other taps, held elsewhere
  input  wire logic [4*SIDE_W-1:0]   ext_coeff_i,
  input  wire logic [5*SIDE_W-1:0]   chan_b_own_i,
  output logic      [5*SIDE_W-1:0]   chan_b_coeff_o,
  output logic                       merged_o,
  // Sample stream
  input  wire logic                  smp_valid_i,
  input  wire logic [SMP_W-1:0]      smp_i,
  output logic                       y_valid_o,
  output logic      [OUT_W-1:0]      y_o
);

  logic [SIDE_W-1:0]   tap2_r, tap3_r, tap4_r, tap6_r;
  logic [SIDE_W-1:0]   tap2_nxt, tap3_nxt, tap4_nxt, tap6_nxt;
  logic [CENTER_W-1:0] ctr_r, ctr_nxt;
  logic [7:0]          cfg_r, cfg_nxt;
  logic                ack_r, ack_nxt;
  logic [31:0]         dat_r, dat_nxt;
  logic                req;
  logic [11:0]         idx;
  logic [31:0]         wmask;
  logic [31:0]         old_w, new_w;

  assign req   = wb_cyc_i && wb_stb_i && !ack_r;
  assign idx   = wb_adr_i[13:2];
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Register file: answer one cycle after the request; unmapped reads zero
  always_comb begin
    tap2_nxt = tap2_r;
    tap3_nxt = tap3_r;
    tap4_nxt = tap4_r;
    tap6_nxt = tap6_r;
    ctr_nxt  = ctr_r;
    cfg_nxt  = cfg_r;
    ack_nxt  = req;
    case (idx)
      IDX_CFG:    old_w = {24'h000000, cfg_r};
      IDX_TAP2:   old_w = {20'h00000, tap2_r};
      IDX_TAP3:   old_w = {20'h00000, tap3_r};
      IDX_TAP4:   old_w = {20'h00000, tap4_r};
      IDX_CENTER: old_w = {14'h0000, ctr_r};
      IDX_TAP6:   old_w = {20'h00000, tap6_r};
      default:    old_w = '0;
    endcase
    // Byte lanes left out by sel keep their old contents
    new_w   = (old_w & ~wmask) | (wb_dat_i & wmask);
    dat_nxt = (req && !wb_we_i) ? old_w : '0;
    if (req && wb_we_i) begin
      case (idx)
        IDX_CFG:    cfg_nxt  = new_w[$bits(cfg_r)-1:0] & CFG_MASK;
        IDX_TAP2:   tap2_nxt = new_w[SIDE_W-1:0];
        IDX_TAP3:   tap3_nxt = new_w[SIDE_W-1:0];
        IDX_TAP4:   tap4_nxt = new_w[SIDE_W-1:0];
        IDX_CENTER: ctr_nxt  = new_w[CENTER_W-1:0];
        IDX_TAP6:   tap6_nxt = new_w[SIDE_W-1:0];
        default:    ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tap2_r <= COEFF_RST[SIDE_W-1:0];
      tap3_r <= COEFF_RST[SIDE_W-1:0];
      tap4_r <= COEFF_RST[SIDE_W-1:0];
      tap6_r <= COEFF_RST[SIDE_W-1:0];
      ctr_r  <= COEFF_RST[CENTER_W-1:0];
      cfg_r  <= CFG_RST;
      ack_r  <= 1'b0;
      dat_r  <= '0;
    end else begin
      tap2_r <= tap2_nxt;
      tap3_r <= tap3_nxt;
      tap4_r <= tap4_nxt;
      tap6_r <= tap6_nxt;
      ctr_r  <= ctr_nxt;
      cfg_r  <= cfg_nxt;
      ack_r  <= ack_nxt;
      dat_r  <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // Filter datapath. The settings are not double-buffered, so a change
  // while data flows corrupts a few outputs; software must stop the link.
  logic [1:0]              mode;
  logic [2:0]              scw;
  logic [NTAPS*SMP_W-1:0]  hist;
  logic signed [ACC_W-1:0] prod [NTAPS];
  logic signed [ACC_W-1:0] acc;
  logic signed [CENTER_W-1:0] coef [NTAPS];

  assign mode = cfg_r[CFG_MODE_LSB +: 2];
  // Out-of-range weight values are clamped to the largest legal weight
  assign scw  = (cfg_r[CFG_SCW_LSB +: 3] > SCW_MAX) ? SCW_MAX : cfg_r[CFG_SCW_LSB +: 3];

  always_comb begin
    coef[0] = CENTER_W'(signed'(ext_coeff_i[0*SIDE_W +: SIDE_W]));
    coef[1] = CENTER_W'(signed'(tap2_r));
    coef[2] = CENTER_W'(signed'(tap3_r));
    coef[3] = CENTER_W'(signed'(tap4_r));
    coef[4] = signed'(ctr_r);
    coef[5] = CENTER_W'(signed'(tap6_r));
    coef[6] = CENTER_W'(signed'(ext_coeff_i[1*SIDE_W +: SIDE_W]));
    coef[7] = CENTER_W'(signed'(ext_coeff_i[2*SIDE_W +: SIDE_W]));
    coef[8] = CENTER_W'(signed'(ext_coeff_i[3*SIDE_W +: SIDE_W]));
  end

  fecb_tapline #(
    .W (SMP_W),
    .N (NTAPS)
  ) u_tapline (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .shift_i   (smp_valid_i),
    .sample_i  (smp_i),
    .taps_o    (hist)
  );

  // Center tap always carries weight 2^-16; side taps are shifted up by scw
  genvar g;
  generate
    for (g = 0; g < NTAPS; g++) begin : g_tap
      logic signed [ACC_W-1:0] raw;
      assign raw = ACC_W'(signed'(hist[g*SMP_W +: SMP_W])) * ACC_W'(coef[g]);
      if (g == CTR_TAP) begin : g_ctr
        assign prod[g] = raw;
      end else begin : g_side
        assign prod[g] = raw <<< scw;
      end
    end
  endgenerate

  always_comb begin
    acc = '0;
    for (int i = 0; i < NTAPS; i++) begin
      acc = acc + prod[i];
    end
  end

  logic             yv_r, yv_nxt;
  logic             yv2_r, yv2_nxt;
  logic [OUT_W-1:0] y_r, y_nxt;
  logic [5*SIDE_W-1:0] cb_r, cb_nxt;
  logic             mrg_r, mrg_nxt;

  always_comb begin
    yv_nxt  = smp_valid_i;
    yv2_nxt = yv_r;
    y_nxt   = y_r;
    mrg_nxt = cfg_r[CFG_MERGE_BIT];
    // With share set, channel B takes this bank's four side taps and the center; center is truncated
    cb_nxt  = cfg_r[CFG_SHARE_BIT] ? {tap6_r, ctr_r[SIDE_W-1:0], tap4_r, tap3_r, tap2_r}
                                   : chan_b_own_i;
    if (yv_r) begin
      if (mode == MODE_RUN) begin
        y_nxt = acc[FRAC_W +: OUT_W];
      end else begin
        y_nxt = OUT_W'(signed'(hist[CTR_TAP*SMP_W +: SMP_W]));
      end
    end
  end

  // Output word lands one cycle after the history shifted
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      yv_r  <= 1'b0;
      yv2_r <= 1'b0;
      y_r   <= '0;
      cb_r  <= '0;
      mrg_r <= 1'b0;
    end else begin
      yv_r  <= yv_nxt;
      yv2_r <= yv2_nxt;
      y_r   <= y_nxt;
      cb_r  <= cb_nxt;
      mrg_r <= mrg_nxt;
    end
  end

  assign y_valid_o      = yv2_r;
  assign y_o            = y_r;
  assign chan_b_coeff_o = cb_r;
  assign merged_o       = mrg_r;

  default clocking cb_clk @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence wr_s(logic [11:0] i);
    req && wb_we_i && idx == i && wb_sel_i == 4'hf;
  endsequence
  sequence rd_s(logic [11:0] i);
    req && !wb_we_i && idx == i;
  endsequence

  ack_answer_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse after request");
  tap3_store_a: assert property (wr_s(IDX_TAP3) |=> tap3_r == $past(wb_dat_i[11:0]))
    else $error("third tap not stored");
  tap4_store_a: assert property (wr_s(IDX_TAP4) |=> tap4_r == $past(wb_dat_i[11:0]))
    else $error("fourth tap not stored");
  center_read_a: assert property (rd_s(IDX_CENTER) |=> wb_dat_o[31:18] == '0
                                  && wb_dat_o[17:0] == $past(ctr_r))
    else $error("center tap readback wrong");
  merge_follow_a: assert property (1'b1 |=> merged_o == $past(cfg_r[CFG_MERGE_BIT]))
    else $error("merged flag not following config");
  share_sel_a: assert property (cfg_r[CFG_SHARE_BIT] |=>
                                chan_b_coeff_o[SIDE_W-1:0] == $past(tap2_r))
    else $error("channel B not given shared taps");
  bypass_out_a: assert property (yv_r && mode != MODE_RUN |=>
                                 y_o == OUT_W'(signed'($past(hist[CTR_TAP*SMP_W +: SMP_W])))
                                 && y_valid_o)
    else $error("bypass output wrong");
  run_out_a: assert property (yv_r && mode == MODE_RUN |=>
                              y_o == $past(acc[FRAC_W +: OUT_W]))
    else $error("filter sum not delivered");
  weight_max_a: assert property (scw <= SCW_MAX && (cfg_r[CFG_SCW_LSB +: 3] > SCW_MAX
                                 || scw == cfg_r[CFG_SCW_LSB +: 3]))
    else $error("side weight not taken from config");
  reset_zero_a: assert property (disable iff (1'b0) !rst_n_i |=>
                                 tap2_r == '0 && tap3_r == '0 && tap4_r == '0
                                 && tap6_r == '0 && ctr_r == '0)
    else $error("coefficients not cleared by reset");

endmodule : fecb_bank
`default_nettype wire

// [shared/fecb_pkg.sv]
package fecb_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [11:0] IDX_CFG    = 12'h400;
  localparam logic [11:0] IDX_TAP2   = 12'h41a;
  localparam logic [11:0] IDX_TAP3   = 12'h41c;
  localparam logic [11:0] IDX_TAP4   = 12'h41e;
  localparam logic [11:0] IDX_CENTER = 12'h420;
  localparam logic [11:0] IDX_TAP6   = 12'h423;

  // Widths
  localparam int SMP_W    = 12;
  localparam int SIDE_W   = 12;
  localparam int CENTER_W = 18;
  localparam int NTAPS    = 9;
  localparam int CTR_TAP  = 4;
  localparam int ACC_W    = 40;
  localparam int FRAC_W   = 16;
  localparam int OUT_W    = 20;

  // Configuration register fields
  localparam int CFG_MODE_LSB  = 0;
  localparam int CFG_SCW_LSB   = 2;
  localparam int CFG_MERGE_BIT = 5;
  localparam int CFG_SHARE_BIT = 6;
  localparam logic [7:0] CFG_MASK = 8'h7f;

  localparam logic [1:0] MODE_BYPASS = 2'h0;
  localparam logic [1:0] MODE_RUN    = 2'h2;
  localparam logic [2:0] SCW_MAX     = 3'h6;

  localparam logic [23:0] COEFF_RST = 24'h000000;
  localparam logic [7:0]  CFG_RST   = 8'h00;

endpackage : fecb_pkg

// [logic/fecb_tapline.sv]
`timescale 1ns/1ps
`default_nettype none
// Sample history for the nine taps; newest sample sits at index 0
module fecb_tapline
  import fecb_pkg::*;
#(
  parameter int W = SMP_W,
  parameter int N = NTAPS
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  // Sample stream
  input  wire logic             shift_i,
  input  wire logic [W-1:0]     sample_i,
  output logic      [N*W-1:0]   taps_o
);

  logic [N*W-1:0] taps_r;
  logic [N*W-1:0] taps_nxt;

  always_comb begin
    taps_nxt = taps_r;
    if (shift_i) begin
      taps_nxt = {taps_r[(N-1)*W-1:0], sample_i};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      taps_r <= '0;
    end else begin
      taps_r <= taps_nxt;
    end
  end

  assign taps_o = taps_r;

endmodule : fecb_tapline
`default_nettype wire

// [tb/fecb_sample_src.sv]
`timescale 1ns/1ps
`default_nettype none
// Converter sample cores feeding the filter
module fecb_sample_src
  import fecb_pkg::*;
(
  // Clock
  input  wire logic             clk_i,
  // Sample stream
  output logic                  vld_o,
  output logic      [SMP_W-1:0] smp_o
);
  initial begin
    vld_o = 1'b0;
    smp_o = '0;
  end
  // Gap 0 keeps the strobe up so the next sample follows back to back
  task automatic send(input logic [SMP_W-1:0] s, input int gap);
    @(posedge clk_i);
    vld_o <= 1'b1;
    smp_o <= s;
    repeat (gap) begin
      @(posedge clk_i);
      vld_o <= 1'b0;
      smp_o <= ~s; // Line not held once the strobe drops
    end
  endtask : send
endmodule : fecb_sample_src
`default_nettype wire

// [tb/tb_fir_equalizer_coeff_bank_a.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_fir_equalizer_coeff_bank_a
  import fecb_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [13:0] adr = '0;
  logic [3:0]  sel = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic        ack;
  logic [47:0] ext = '0;
  logic [59:0] bown = '0;
  logic [59:0] bco;
  logic        merged;
  logic        sv;
  logic [11:0] sd;
  logic        yv;
  logic [19:0] y;
  logic [7:0]  cfg = '0;
  int          err_total = 0;
  int          checks_done = 0;
  logic [31:0] bq[$];
  logic [19:0] yq[$];
  longint      h[9];
  longint      c[9];
  logic [11:0] ix[6] = '{IDX_TAP2, IDX_TAP3, IDX_TAP4, IDX_CENTER, IDX_TAP6, IDX_CFG};

  always #4 clk = ~clk;

  fecb_sample_src src (.clk_i(clk), .vld_o(sv), .smp_o(sd));
  fecb_bank DUT (
    .clk_sys_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_coeff_i(ext), .chan_b_own_i(bown), .chan_b_coeff_o(bco), .merged_o(merged),
    .smp_valid_i(sv), .smp_i(sd), .y_valid_o(yv), .y_o(y));

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // Writes answer with zero data, so every acknowledge has a note
  task automatic wb(input logic w, input logic [11:0] i, input logic [3:0] s,
                    input logic [31:0] d, input logic [31:0] exp);
    bq.push_back(w ? 32'h0 : exp);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    sel <= s;
    wdat <= d;
    // The wait ends when the acknowledge comes; the watchdog only ends a lost one
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic setc(input int k, input logic [11:0] i, input logic [31:0] d);
    wb(1'b1, i, 4'hf, d, 32'h0);
    c[k] = (k == 4) ? longint'($signed(d[17:0])) : longint'($signed(d[11:0]));
    wb(1'b0, i, 4'hf, 32'h0, (k == 4) ? {14'h0, d[17:0]} : {20'h0, d[11:0]});
  endtask : setc

  task automatic setcfg(input logic [7:0] v);
    cfg = v & CFG_MASK;
    wb(1'b1, IDX_CFG, 4'hf, {24'h0, v}, 32'h0);
    wb(1'b0, IDX_CFG, 4'hf, 32'h0, {24'h0, cfg});
  endtask : setcfg

  task automatic push(input logic [11:0] s, input int gap);
    longint acc;
    int scw;
    scw = (cfg[4:2] > SCW_MAX) ? 6 : int'(cfg[4:2]);
    for (int i = 8; i > 0; i--) h[i] = h[i-1];
    h[0] = longint'($signed(s));
    acc = c[4] * h[4];
    for (int i = 0; i < 9; i++) if (i != 4) acc += (c[i] * h[i]) <<< scw;
    if (cfg[1:0] == MODE_RUN) yq.push_back(acc[35:16]);
    else yq.push_back(20'(h[4]));
    src.send(s, gap);
  endtask : push

  always @(posedge clk) begin
    if (ack === 1'b1) begin
      check("wb_ack_o", bq.size() > 0, 64'h1);
      if (bq.size() > 0) check("wb_dat_o", rdat, bq.pop_front());
    end
    if (yv === 1'b1) begin
      check("y_valid_o", yq.size() > 0, 64'h1);
      if (yq.size() > 0) check("y_o", y, yq.pop_front());
    end
  end

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    check("chan_b_coeff_o", bco, 64'h0);
    check("merged_o", merged, 64'h0);
    rst_n <= 1'b1;
    h = '{default: 0};
    // Taps held outside this bank keep their values
    for (int k = 1; k < 6; k++) c[k] = 0;
    cfg = '0;
    foreach (ix[i]) wb(1'b0, ix[i], 4'hf, 32'h0, 32'h0);
    // Share is cleared by reset, so channel B falls back to its own set
    check("chan_b_coeff_o", bco, bown);
  endtask : do_reset

  initial begin
    logic [47:0] e;
    void'($urandom(32'h18524b55));
    do_reset();
    wb(1'b1, 12'h41b, 4'hf, 32'hffffffff, 32'h0);
    wb(1'b0, 12'h41b, 4'hf, 32'h0, 32'h0);
    setc(5, IDX_TAP6, 32'h00000abc);
    wb(1'b1, IDX_TAP6, 4'h2, 32'h00000500, 32'h0);
    wb(1'b0, IDX_TAP6, 4'hf, 32'h0, 32'h000005bc);
    for (int i = 0; i < 5; i++) setc(i + 1, ix[i], 32'hffffffff);
    for (int i = 0; i < 5; i++) setc(i + 1, ix[i], $urandom());
    e = 48'({$urandom(), $urandom()});
    @(posedge clk);
    ext <= e;
    bown <= 60'({$urandom(), $urandom()});
    for (int i = 0; i < 4; i++) c[(i == 0) ? 0 : i + 5] = longint'($signed(e[12*i +: 12]));
    for (int m = 0; m < 4; m++) begin
      for (int w = 0; w < 8; w++) begin
        setcfg(8'(m | (w << 2)));
        repeat (10) push(12'($urandom()), $urandom_range(2));
        push(12'h800, 3);
      end
    end
    setcfg(8'he0);
    repeat (2) @(posedge clk);
    check("chan_b_coeff_o", bco, {c[5][11:0], c[4][11:0], c[3][11:0], c[2][11:0], c[1][11:0]});
    check("merged_o", merged, 64'h1);
    setcfg(8'h00);
    repeat (2) @(posedge clk);
    check("chan_b_coeff_o", bco, bown);
    check("merged_o", merged, 64'h0);
    @(posedge clk);
    do_reset();
    repeat (4) @(posedge clk);
    check("pending", bq.size() + yq.size(), 64'h0);
    complete_run();
  end

  initial begin
    #400000;
    err_total++;
    complete_run();
  end
endmodule : tb_fir_equalizer_coeff_bank_a
`default_nettype wire
